// *** scr_consts.svh ***
// offsets, field positions and reset values of the supervisor register bank
// assumes byte addresses on an 8-bit register port, one 32-bit word per register
`ifndef SCR_CONSTS_SVH
`define SCR_CONSTS_SVH

// register offsets
`define SCR_OFS_SR     8'h00
`define SCR_OFS_CCR    8'h04
`define SCR_OFS_VBR    8'h08
`define SCR_OFS_CACHE_SETUP_REGISTER   8'h0c
`define SCR_OFS_ACR0   8'h10
`define SCR_ACR_STRIDE 8'h04
`define SCR_OFS_LOCAL_SRAM_BASE 8'h18
`define SCR_OFS_PERIPHERAL_WINDOW_BASE   8'h1c

// state word
`define SCR_SR_RESET   16'h2700
`define SCR_SR_WMASK   16'hb71f
`define SCR_CCR_WMASK  8'h1f
`define SCR_SR_T       15
`define SCR_SR_S       13
`define SCR_SR_M       12
`define SCR_SR_IPL_HI  10
`define SCR_SR_IPL_LO  8
`define SCR_CCR_HI     4

// vector base
`define SCR_VBR_LO     20

// cache setup fields
`define SCR_CA_IC_EN   31
`define SCR_CA_DC_EN   30
`define SCR_CA_BC_EN   29
`define SCR_CA_DCM_HI  9
`define SCR_CA_DCM_LO  8
`define SCR_CA_ICM_HI  7
`define SCR_CA_ICM_LO  6
`define SCR_CA_DWP     5

// region attribute fields
`define SCR_AC_BASE_HI 31
`define SCR_AC_BASE_LO 24
`define SCR_AC_MASK_HI 23
`define SCR_AC_MASK_LO 16
`define SCR_AC_EN      15
`define SCR_AC_CM_HI   6
`define SCR_AC_CM_LO   5
`define SCR_AC_WP      2

// sram and peripheral window bases
`define SCR_RAM_LO     12
`define SCR_RAM_WP     8
`define SCR_RAM_SUP    1
`define SCR_MB_LO      16
`define SCR_BASE_V     0

`endif

// *** scr_pkg.sv ***
// types carried by the supervisor register bank
// assumes the bank and its users agree on these packed layouts
package scr_pkg;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} scr_bus_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
		logic        write;
		logic        instr;
		logic        user;
	} scr_lookup_t;

	typedef struct packed {
		logic       valid;
		logic       region_hit;
		logic       wp;
		logic [1:0] cm;
		logic       sram_hit;
		logic       sram_fault;
		logic       periph_hit;
	} scr_attr_t;

	typedef struct packed {
		logic       trace;
		logic       supervisor;
		logic       master;
		logic [2:0] ipl;
		logic [4:0] condition_flags_byte;
	} scr_mode_t;

	typedef struct packed {
		logic       ic_en;
		logic       dc_en;
		logic       bc_en;
		logic [1:0] ic_cm;
		logic [1:0] dc_cm;
		logic       dflt_wp;
	} scr_cache_t;

endpackage

// *** scr_properties.sv ***
// port assertions for the supervisor register bank
// assumes one clock domain, reset synchronous and active high
`timescale 1ns/1ps
`include "scr_consts.svh"

module scr_properties #(
	parameter int NREG = 2
) (
	// clock and control
	input wire logic                 clk_sys,
	input wire logic                 sys_rst,
	input wire logic                 ce,
	// register port
	input wire scr_pkg::scr_bus_t    bus,
	input wire logic [31:0]          rdata,
	input wire logic                 priv_fault,
	// immediate write
	input wire logic                 imm_sr_valid,
	input wire logic [15:0]          imm_sr_data,
	input wire logic                 imm_sr_done,
	// vectors, lookups and state
	input wire logic [7:0]           vec_num,
	input wire logic [31:0]          vec_addr,
	input wire scr_pkg::scr_lookup_t lk,
	input wire scr_pkg::scr_attr_t   attr,
	input wire scr_pkg::scr_mode_t   mode
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	sequence s_rd(logic [7:0] o);
		ce && bus.rd && bus.addr == o && mode.supervisor;
	endsequence
	sequence s_imm;
		ce && imm_sr_valid && mode.supervisor;
	endsequence

	property p_sr_view;
		s_rd(`SCR_OFS_SR) |=> rdata[31:16] == 16'h0 && rdata[13] == $past(mode.supervisor)
			&& rdata[10:8] == $past(mode.ipl) && rdata[4:0] == $past(mode.condition_flags_byte);
	endproperty
	a_sr_view: assert property (p_sr_view) else $error("state word read wrong");
	property p_ccr_view;
		s_rd(`SCR_OFS_CCR) |=> rdata == {27'h0, $past(mode.condition_flags_byte)};
	endproperty
	a_ccr_view: assert property (p_ccr_view) else $error("condition byte read wrong");
	property p_vbr_low;
		s_rd(`SCR_OFS_VBR) |=> rdata[19:0] == 20'h0;
	endproperty
	a_vbr_low: assert property (p_vbr_low) else $error("vector base low bits set");
	property p_vec;
		ce |=> vec_addr[19:0] == {10'h0, $past(vec_num), 2'h0};
	endproperty
	a_vec: assert property (p_vec) else $error("vector address offset wrong");
	property p_imm_done;
		imm_sr_done == (imm_sr_valid && ce && mode.supervisor);
	endproperty
	a_imm_done: assert property (p_imm_done) else $error("immediate done wrong");
	property p_imm_sr;
		s_imm |=> mode.supervisor == $past(imm_sr_data[13]) && mode.ipl == $past(imm_sr_data[10:8])
			&& mode.condition_flags_byte == $past(imm_sr_data[4:0]);
	endproperty
	a_imm_sr: assert property (p_imm_sr) else $error("immediate write not in one cycle");
	property p_priv;
		ce && !mode.supervisor && (bus.rd || bus.wr) && bus.addr != `SCR_OFS_CCR
			&& bus.addr[1:0] == 2'h0 && bus.addr <= `SCR_OFS_PERIPHERAL_WINDOW_BASE |=> priv_fault && rdata == 32'h0;
	endproperty
	a_priv: assert property (p_priv) else $error("user access not refused");
	property p_no_fault;
		ce && mode.supervisor && !imm_sr_valid |=> !priv_fault;
	endproperty
	a_no_fault: assert property (p_no_fault) else $error("fault in supervisor mode");
	property p_lk_idle;
		ce && !lk.valid |=> !attr.valid && !attr.region_hit && !attr.sram_hit && !attr.periph_hit;
	endproperty
	a_lk_idle: assert property (p_lk_idle) else $error("hit without lookup");
endmodule

bind scr_regs scr_properties #(.NREG(NREG)) u_scr_properties (.clk_sys(clk_sys),
	.sys_rst(sys_rst), .ce(ce), .bus(bus), .rdata(rdata), .priv_fault(priv_fault),
	.imm_sr_valid(imm_sr_valid), .imm_sr_data(imm_sr_data), .imm_sr_done(imm_sr_done),
	.vec_num(vec_num), .vec_addr(vec_addr), .lk(lk), .attr(attr), .mode(mode));

// *** scr_regs.sv ***
// supervisor control register bank: state word, vector base, cache setup,
// region attributes, sram base and peripheral window base
// assumes the core drives the register port, lookups and vector requests
// on clk_sys, so no input needs a synchroniser
//
// Notes on behaviour
// - upper state byte: interrupt mask, mode flags
// - low state byte is the condition byte
// - vector base supplies upper 12 address bits
// - low 20 vector base bits read zero
// - cache setup: instruction, data, branch controls
// - cache setup gives default space attributes
// - two regions: location, protect, cache mode
// - sram placed at its base, attributes enforced
// - peripheral window decoded at its base
// - immediate state word write takes one cycle
`timescale 1ns/1ps
`include "scr_consts.svh"

// one region attribute register with its address match; the regions form
// a chain in which each one passes on what the regions below it decided
module scr_region #(
	parameter int TOP_W = `SCR_AC_BASE_HI - `SCR_AC_BASE_LO + 1
) (
	// clock and reset
	input  wire logic               clk_sys,
	input  wire logic               sys_rst,
	// register write and read back
	input  wire logic               wr_en,
	input  wire logic [31:0]        wdata,
	output logic [31:0]             value,
	// lookup chain
	input  wire logic [TOP_W-1:0]   lk_top,
	input  wire scr_pkg::scr_attr_t below,
	output scr_pkg::scr_attr_t      result
);

	wire [TOP_W-1:0] base;
	wire [TOP_W-1:0] amask;
	wire             match;

	assign base  = value[`SCR_AC_BASE_HI:`SCR_AC_BASE_LO];
	assign amask = value[`SCR_AC_MASK_HI:`SCR_AC_MASK_LO];
	// masked bits of the address take no part in the compare
	assign match = value[`SCR_AC_EN] & (((lk_top ^ base) & ~amask) == '0);

	// a hit here overrides whatever the chain below decided
	always_comb begin
		result = below;
		if (match) begin
			result.region_hit = 1'b1;
			result.wp         = value[`SCR_AC_WP];
			result.cm         = value[`SCR_AC_CM_HI:`SCR_AC_CM_LO];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			value <= 32'h0;
		end else if (wr_en) begin
			value <= wdata;
		end
	end

endmodule

module scr_regs #(
	parameter int NREG = 2
) (
	// clock, reset, enable
	input  wire logic              clk_sys,
	input  wire logic              sys_rst,
	input  wire logic              ce,
	// register port
	input  wire scr_pkg::scr_bus_t bus,
	output logic [31:0]            rdata,
	output logic                   priv_fault,
	// immediate state word write
	input  wire logic              imm_sr_valid,
	input  wire logic [15:0]       imm_sr_data,
	output logic                   imm_sr_done,
	// exception vector fetch
	input  wire logic [7:0]        vec_num,
	output logic [31:0]            vec_addr,
	// attribute lookup
	input  wire scr_pkg::scr_lookup_t lk,
	output scr_pkg::scr_attr_t     attr,
	// state and configuration
	output scr_pkg::scr_mode_t     mode,
	output scr_pkg::scr_cache_t    cache_cfg
);

	logic [15:0] sr;
	logic [11:0] vbr_hi;
	logic [31:0] cache_setup_register;
	logic [31:0] acr [NREG];
	logic [31:0] local_sram_base;
	logic [31:0] peripheral_window_base;

	// ---- access decode
	wire is_sup;
	wire hit_sr;
	wire hit_ccr;
	wire hit_vbr;
	wire hit_cache_setup_register;
	wire hit_ram;
	wire hit_mb;
	wire [NREG-1:0] hit_acr;
	wire any_hit;
	wire allowed;
	wire wr_ok;
	wire rd_ok;
	wire imm_ok;
	wire viol;

	assign is_sup   = sr[`SCR_SR_S];
	assign hit_sr   = bus.addr == `SCR_OFS_SR;
	assign hit_ccr  = bus.addr == `SCR_OFS_CCR;
	assign hit_vbr  = bus.addr == `SCR_OFS_VBR;
	assign hit_cache_setup_register = bus.addr == `SCR_OFS_CACHE_SETUP_REGISTER;
	assign hit_ram  = bus.addr == `SCR_OFS_LOCAL_SRAM_BASE;
	assign hit_mb   = bus.addr == `SCR_OFS_PERIPHERAL_WINDOW_BASE;

	// the condition byte stays reachable from user mode, as its own
	// view is a user-level register; everything else is supervisor only
	assign allowed = is_sup | hit_ccr;
	assign wr_ok   = ce & bus.wr & allowed;
	assign rd_ok   = bus.rd & allowed;
	assign imm_ok  = ce & imm_sr_valid & is_sup;
	assign viol    = ((bus.wr | bus.rd) & ~allowed) | (imm_sr_valid & ~is_sup);

	// ---- region registers and their decode
	logic [31:0] acr_rd [NREG+1];
	scr_pkg::scr_attr_t res [NREG+1];

	assign acr_rd[NREG] = 32'h0;

	// default attributes when no region claims the address
	assign res[NREG].valid      = 1'b0;
	assign res[NREG].region_hit = 1'b0;
	assign res[NREG].wp         = cache_setup_register[`SCR_CA_DWP] & ~lk.instr;
	assign res[NREG].cm         = lk.instr ? cache_setup_register[`SCR_CA_ICM_HI:`SCR_CA_ICM_LO]
	                                       : cache_setup_register[`SCR_CA_DCM_HI:`SCR_CA_DCM_LO];
	assign res[NREG].sram_hit   = 1'b0;
	assign res[NREG].sram_fault = 1'b0;
	assign res[NREG].periph_hit = 1'b0;

	genvar gi;
	generate
		for (gi = 0; gi < NREG; gi++) begin : g_acr
			wire [7:0] ofs;

			assign ofs         = `SCR_OFS_ACR0 + 8'(gi) * `SCR_ACR_STRIDE;
			assign hit_acr[gi] = bus.addr == ofs;
			assign acr_rd[gi]  = hit_acr[gi] ? acr[gi] : acr_rd[gi+1];

			// lower-numbered region wins where two overlap
			scr_region u_scr_region (
				.clk_sys (clk_sys),
				.sys_rst (sys_rst),
				.wr_en   (wr_ok & hit_acr[gi]),
				.wdata   (bus.wdata),
				.value   (acr[gi]),
				.lk_top  (lk.addr[`SCR_AC_BASE_HI:`SCR_AC_BASE_LO]),
				.below   (res[gi+1]),
				.result  (res[gi])
			);
		end
	endgenerate

	assign any_hit = hit_sr | hit_ccr | hit_vbr | hit_cache_setup_register | hit_ram | hit_mb | (|hit_acr);

	// ---- read selection
	wire [31:0] vbr_full;
	wire [31:0] rd_val;

	assign vbr_full = {vbr_hi, 20'h0};

	assign rd_val = hit_sr   ? {16'h0, sr} :
	                hit_ccr  ? {24'h0, sr[7:0]} :
	                hit_vbr  ? vbr_full :
	                hit_cache_setup_register ? cache_setup_register :
	                hit_ram  ? local_sram_base :
	                hit_mb   ? peripheral_window_base :
	                any_hit  ? acr_rd[0] : 32'h0;

	// ---- next state word
	wire [15:0] next_sr;

	// the immediate path has priority over a port write in the same cycle
	assign next_sr = imm_ok ? (imm_sr_data & `SCR_SR_WMASK) :
	                 (wr_ok & hit_sr) ? (bus.wdata[15:0] & `SCR_SR_WMASK) :
	                 (wr_ok & hit_ccr) ? {sr[15:8], bus.wdata[7:0] & `SCR_CCR_WMASK} :
	                 sr;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sr <= `SCR_SR_RESET;
		end else if (ce) begin
			sr <= next_sr;
		end
	end

	// no bus cycle is spent: the write lands at the same edge it is offered
	assign imm_sr_done = imm_ok;

	// ---- configuration registers
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			vbr_hi <= 12'h0;
			cache_setup_register   <= 32'h0;
			local_sram_base <= 32'h0;
			peripheral_window_base   <= 32'h0;
		end else if (wr_ok) begin
			if (hit_vbr) begin
				vbr_hi <= bus.wdata[31:`SCR_VBR_LO];
			end
			if (hit_cache_setup_register) begin
				cache_setup_register <= bus.wdata;
			end
			if (hit_ram) begin
				local_sram_base <= bus.wdata;
			end
			if (hit_mb) begin
				peripheral_window_base <= bus.wdata;
			end
		end
	end

	// ---- read data and privilege fault
	// rdata drops to zero outside the answer cycle in cycles with ce high; with ce
	// low it holds its last word, so a stale word can stay on the port
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rdata      <= 32'h0;
			priv_fault <= 1'b0;
		end else if (ce) begin
			rdata      <= rd_ok ? rd_val : 32'h0;
			priv_fault <= viol;
		end
	end

	// ---- exception vector address
	wire [31:0] next_vec;

	assign next_vec = vbr_full + {22'h0, vec_num, 2'h0};

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			vec_addr <= 32'h0;
		end else if (ce) begin
			vec_addr <= next_vec;
		end
	end

	// ---- sram and peripheral window decode
	wire ram_hit;
	wire ram_fault;
	wire mb_hit;

	assign ram_hit   = local_sram_base[`SCR_BASE_V]
	                   & (lk.addr[31:`SCR_RAM_LO] == local_sram_base[31:`SCR_RAM_LO]);
	assign ram_fault = ram_hit & ((lk.write & local_sram_base[`SCR_RAM_WP])
	                   | (lk.user & local_sram_base[`SCR_RAM_SUP]));
	assign mb_hit    = peripheral_window_base[`SCR_BASE_V]
	                   & (lk.addr[31:`SCR_MB_LO] == peripheral_window_base[31:`SCR_MB_LO]);

	scr_pkg::scr_attr_t next_attr;

	always_comb begin
		next_attr            = res[0];
		next_attr.valid      = lk.valid;
		next_attr.sram_hit   = lk.valid & ram_hit;
		next_attr.sram_fault = lk.valid & ram_fault;
		next_attr.periph_hit = lk.valid & mb_hit;
		if (!lk.valid) begin
			next_attr.region_hit = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			attr <= '0;
		end else if (ce) begin
			attr <= next_attr;
		end
	end

	// ---- state and configuration views
	// these come straight off the register bits, so they follow a write
	// one edge later with no extra stage
	assign mode.trace      = sr[`SCR_SR_T];
	assign mode.supervisor = sr[`SCR_SR_S];
	assign mode.master     = sr[`SCR_SR_M];
	assign mode.ipl        = sr[`SCR_SR_IPL_HI:`SCR_SR_IPL_LO];
	assign mode.condition_flags_byte        = sr[`SCR_CCR_HI:0];

	assign cache_cfg.ic_en   = cache_setup_register[`SCR_CA_IC_EN];
	assign cache_cfg.dc_en   = cache_setup_register[`SCR_CA_DC_EN];
	assign cache_cfg.bc_en   = cache_setup_register[`SCR_CA_BC_EN];
	assign cache_cfg.ic_cm   = cache_setup_register[`SCR_CA_ICM_HI:`SCR_CA_ICM_LO];
	assign cache_cfg.dc_cm   = cache_setup_register[`SCR_CA_DCM_HI:`SCR_CA_DCM_LO];
	assign cache_cfg.dflt_wp = cache_setup_register[`SCR_CA_DWP];

endmodule

// *** tb.sv ***
// self-checking bench for the supervisor register bank
// assumes reads answer one cycle after the strobe and lookups one cycle after they are driven
`timescale 1ns/1ps
`include "scr_consts.svh"

module tb;
	logic                 clk_sys, sys_rst, ce, imm_sr_valid, imm_sr_done, priv_fault;
	logic [15:0]          imm_sr_data;
	logic [7:0]           vec_num;
	logic [31:0]          rdata, vec_addr, d;
	logic [7:0]           ofs [9] = '{8'h0, 8'h4, 8'h8, 8'hc, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
	scr_pkg::scr_bus_t    bus;
	scr_pkg::scr_lookup_t lk;
	scr_pkg::scr_attr_t   attr;
	scr_pkg::scr_mode_t   mode;
	scr_pkg::scr_cache_t  cache_cfg;
	int                   n_mismatch, n_compared;

	scr_regs #(.NREG(2)) u_scr_regs (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .bus(bus),
		.rdata(rdata), .priv_fault(priv_fault), .imm_sr_valid(imm_sr_valid),
		.imm_sr_data(imm_sr_data), .imm_sr_done(imm_sr_done), .vec_num(vec_num),
		.vec_addr(vec_addr), .lk(lk), .attr(attr), .mode(mode), .cache_cfg(cache_cfg));

	initial begin
		clk_sys = 0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic stop_test;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		bus <= '{a, v, 1'b1, 1'b0};
		@(posedge clk_sys);
		bus.wr <= 1'b0;
	endtask

	// the check lands one step after the edge so the answer has settled
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		bus <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk_sys);
		bus.rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask

	task automatic look(input logic [31:0] a, input logic w, input logic i, input logic u);
		@(posedge clk_sys);
		lk <= '{1'b1, a, w, i, u};
		@(posedge clk_sys);
		#1;
	endtask

	function automatic logic [31:0] f_vec(input logic [31:0] b, input logic [7:0] n);
		return {b[31:20], 20'h0} + {22'h0, n, 2'h0};
	endfunction

	initial begin
		bus = '0;
		lk = '0;
		ce = 1;
		imm_sr_valid = 0;
		imm_sr_data = 0;
		vec_num = 0;
		n_mismatch = 0;
		n_compared = 0;
		sys_rst = 1;
		void'($urandom(32'h44cf));
		repeat (5) @(posedge clk_sys);
		sys_rst <= 0;
		for (int k = 0; k < 9; k++)
			rd(ofs[k], k == 0 ? `SCR_SR_RESET : 32'h0);
		for (int k = 0; k < 4; k++) begin
			d = $urandom | 32'h2000;
			wr(`SCR_OFS_SR, d);
			rd(`SCR_OFS_SR, d & 32'hb71f);
			chk({mode.trace, mode.supervisor, mode.master, mode.ipl},
				{d[15], d[13], d[12], d[10:8]});
			d[7:0] = 8'($urandom);
			wr(`SCR_OFS_CCR, d);
			rd(`SCR_OFS_CCR, d & 32'h1f);
			rd(`SCR_OFS_SR, d & 32'hb71f);
			d = k == 0 ? 32'hffffffff : $urandom;
			wr(`SCR_OFS_VBR, d);
			rd(`SCR_OFS_VBR, d & 32'hfff00000);
			@(posedge clk_sys);
			vec_num <= k == 0 ? 8'hff : 8'($urandom);
			@(posedge clk_sys);
			#1 chk(vec_addr, f_vec(d, vec_num));
		end
		$display("test registers done");
		d = $urandom;
		wr(`SCR_OFS_CACHE_SETUP_REGISTER, d);
		#1 chk(cache_cfg, {d[31:29], d[7:6], d[9:8], d[5]});
		look(32'h1234, 1'b1, 1'b0, 1'b0);
		chk({attr.valid, attr.region_hit, attr.wp, attr.cm}, {2'b10, d[5], d[9:8]});
		wr(`SCR_OFS_ACR0, 32'h400f8024);
		wr(`SCR_OFS_ACR0 + `SCR_ACR_STRIDE, 32'h48108040);
		look(32'h48abcdef, 1'b1, 1'b0, 1'b0);
		chk({attr.region_hit, attr.wp, attr.cm}, 4'b1101);
		look(32'h58000000, 1'b0, 1'b0, 1'b0);
		chk({attr.region_hit, attr.wp, attr.cm}, 4'b1010);
		look(32'h60000000, 1'b1, 1'b1, 1'b0);
		chk({attr.region_hit, attr.wp, attr.cm}, {2'b00, d[7:6]});
		wr(`SCR_OFS_LOCAL_SRAM_BASE, 32'h20000103);
		wr(`SCR_OFS_PERIPHERAL_WINDOW_BASE, 32'hfff00001);
		look(32'h20000ffc, 1'b0, 1'b0, 1'b0);
		chk({attr.sram_hit, attr.sram_fault, attr.periph_hit}, 3'b100);
		look(32'h20000004, 1'b1, 1'b0, 1'b0);
		chk({attr.sram_hit, attr.sram_fault}, 2'b11);
		look(32'h20000008, 1'b0, 1'b0, 1'b1);
		chk({attr.sram_hit, attr.sram_fault}, 2'b11);
		look(32'hfff0abcd, 1'b0, 1'b0, 1'b0);
		chk({attr.sram_hit, attr.periph_hit}, 2'b01);
		look(32'h20001000, 1'b0, 1'b0, 1'b0);
		chk({attr.sram_hit, attr.periph_hit}, 2'b00);
		$display("test attributes done");
		@(posedge clk_sys);
		imm_sr_valid <= 1;
		imm_sr_data <= 16'h2513;
		#1 chk(imm_sr_done, 1);
		@(posedge clk_sys);
		imm_sr_data <= 16'h0013;
		#1 chk({imm_sr_done, mode.ipl}, 4'hd);
		@(posedge clk_sys);
		imm_sr_valid <= 0;
		#1 chk({mode.supervisor, mode.condition_flags_byte}, 6'h13);
		rd(`SCR_OFS_VBR, 32'h0);
		chk(priv_fault, 1);
		wr(`SCR_OFS_CCR, 32'h0a);
		rd(`SCR_OFS_CCR, 32'h0a);
		chk(priv_fault, 0);
		wr(`SCR_OFS_SR, 32'h2700);
		rd(`SCR_OFS_SR, 32'h0);
		chk({priv_fault, mode.supervisor}, 2'b10);
		@(posedge clk_sys);
		imm_sr_valid <= 1;
		imm_sr_data <= 16'h2700;
		#1 chk(imm_sr_done, 0);
		@(posedge clk_sys);
		imm_sr_valid <= 0;
		#1 chk({priv_fault, mode.supervisor}, 2'b10);
		@(posedge clk_sys);
		sys_rst <= 1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 0;
		rd(`SCR_OFS_SR, `SCR_SR_RESET);
		$display("test privilege done");
		@(posedge clk_sys);
		ce <= 1'b0;
		wr(`SCR_OFS_VBR, 32'hfff00000);
		@(posedge clk_sys);
		ce <= 1'b1;
		rd(`SCR_OFS_VBR, 32'h0);
		$display("test enable done");
		stop_test();
	end

	// a hang is cut short and counted as a failure
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_mismatch++;
		stop_test();
	end
endmodule
